/* hw/fsx_defs.vh */
/*
  shared constants for the fill / sleep / subtract execution block.
  assumes an 8-bit core with 16-bit instruction words and a 12-bit file address.
*/
`ifndef FSX_DEFS_VH
`define FSX_DEFS_VH

// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define FSX_OPC_FILL_MASK 16'hfe00
`define FSX_OPC_FILL 16'h6800
`define FSX_OPC_SLEEP 16'h0003
`define FSX_OPC_SUBB_MASK 16'hfc00
`define FSX_OPC_SUBB 16'h5400

// ----------------------------------------
// instruction field positions
// ----------------------------------------
`define FSX_BIT_A 8
`define FSX_BIT_D 9

// ----------------------------------------
// addressing constants
// ----------------------------------------
`define FSX_ACC_LOW_MAX 8'h5f
`define FSX_ACC_HIGH_BANK 4'hf
`define FSX_ACC_LOW_BANK 4'h0

// ----------------------------------------
// data and reset values
// ----------------------------------------
`define FSX_ALL_ONES 8'hff
`define FSX_ZERO8 8'h00
`define FSX_WDT_ZERO 16'h0000
`define FSX_POST_ZERO 8'h00
`define FSX_STATUS_RST 7'h60
`define FSX_INSTR_RST 16'h0000
`define FSX_BANK_RST 4'h0
`define FSX_WORD_ZERO 32'h00000000
`define FSX_LANE0 0

// ----------------------------------------
// avalon register offsets (word addresses)
// ----------------------------------------
`define FSX_REG_INSTR 3'h0
`define FSX_REG_WREG 3'h1
`define FSX_REG_BSR 3'h2
`define FSX_REG_STATUS 3'h3
`define FSX_REG_FSR2 3'h4
`define FSX_REG_WDT 3'h5
`define FSX_REG_CFG 3'h6

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define FSX_ST_C 0
`define FSX_ST_DC 1
`define FSX_ST_Z 2
`define FSX_ST_OV 3
`define FSX_ST_N 4
`define FSX_ST_PD 5
`define FSX_ST_TO 6

`endif

/* hw/fsx_exec.v */
/*
  fsx_exec: executes the fill, low-power entry and subtract-with-borrow
  instructions against an internal 4k x 8 data memory.
  assumes an avalon-mm master on i_clk feeds instruction words and reads state;
  other instructions written are ignored.
*/
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "fsx_defs.vh"

// What this block does
// - access bit 0 access bank, else bsr
// - extended set, a=0, f<=95: indexed literal offset
// - fill writes ffh, status flags unchanged
// - sleep clears watchdog counter and postscaler
// - sleep sets expiry flag, clears powerdown flag
module fsx_exec #(
   parameter ADDR_W = 12,
   parameter WDT_W = 16
)(
   input wire i_clk,
   input wire i_reset,
   input wire [2:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   input wire i_wdt_tick,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   output reg o_sleeping
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam ST_IDLE = 3'b001;
   localparam ST_EXEC = 3'b010;
   localparam ST_DONE = 3'b100;

   reg [7:0] mem [0:(1<<ADDR_W)-1];
   reg [2:0] state_r;
   reg [15:0] instr_r;
   reg [7:0] wreg_r;
   reg [3:0] bank_select_reg_r;
   reg [6:0] status_r;
   reg [ADDR_W-1:0] fsr2_r;
   reg [WDT_W-1:0] watchdog_counter_r;
   reg [7:0] postscaler_r;
   reg ext_set_r;
   reg [7:0] fdata_r;

   wire is_fill = (instr_r & `FSX_OPC_FILL_MASK) == `FSX_OPC_FILL;
   wire is_sleep = instr_r == `FSX_OPC_SLEEP;
   wire is_subb = (instr_r & `FSX_OPC_SUBB_MASK) == `FSX_OPC_SUBB;
   wire acc_bit = instr_r[`FSX_BIT_A];
   wire dest_bit = instr_r[`FSX_BIT_D];
   wire [7:0] f_lit = instr_r[7:0];

   // ----------------------------------------
   // effective file address
   // ----------------------------------------
   function [ADDR_W-1:0] eff_addr;
      input [7:0] f;
      input a;
      input ext;
      input [3:0] bank_select_reg;
      input [ADDR_W-1:0] fsr2;
      begin
         if (a)
            eff_addr = {bank_select_reg, f};
         else if (ext && (f <= `FSX_ACC_LOW_MAX))
            eff_addr = fsr2 + {{(ADDR_W-8){1'b0}}, f};
         else if (f <= `FSX_ACC_LOW_MAX)
            eff_addr = {`FSX_ACC_LOW_BANK, f};
         else
            eff_addr = {`FSX_ACC_HIGH_BANK, f};
      end
   endfunction

   wire [ADDR_W-1:0] addr = eff_addr(f_lit, acc_bit, ext_set_r, bank_select_reg_r, fsr2_r);

   // borrow is the inverted carry
   wire [8:0] diff = {1'b0, wreg_r} - {1'b0, fdata_r} - {8'h00, ~status_r[`FSX_ST_C]};
   wire [4:0] ldiff = {1'b0, wreg_r[3:0]} - {1'b0, fdata_r[3:0]} - {4'h0, ~status_r[`FSX_ST_C]};
   wire [7:0] res = diff[7:0];
   wire ovf = (wreg_r[7] != fdata_r[7]) && (res[7] != wreg_r[7]);

   // ----------------------------------------
   // execution and memory
   // ----------------------------------------
   always @(posedge i_clk)
   begin
      if (state_r == ST_EXEC)
         fdata_r <= mem[addr];
      if (state_r == ST_DONE && is_fill)
         mem[addr] <= `FSX_ALL_ONES;
      if (state_r == ST_DONE && is_subb && dest_bit)
         mem[addr] <= res;
   end

   // ----------------------------------------
   // request decode
   // ----------------------------------------
   function hit;
      input [2:0] adr;
      input [2:0] code;
      input take;
      begin
         hit = take && (adr == code);
      end
   endfunction

   // only idle with no answer pending takes a request, so a strobe still high
   // at its own answer edge is not taken a second time
   wire idle = (state_r == ST_IDLE);
   wire finish = (state_r == ST_DONE);
   wire take_wr = idle && i_avs_write && o_avs_waitrequest;
   wire take_rd = idle && !i_avs_write && i_avs_read && o_avs_waitrequest;
   wire lane0 = i_avs_byteenable[`FSX_LANE0];
   wire wr_instr = hit(i_avs_address, `FSX_REG_INSTR, take_wr);
   wire wr_wreg = hit(i_avs_address, `FSX_REG_WREG, take_wr) && lane0;
   wire wr_bsr = hit(i_avs_address, `FSX_REG_BSR, take_wr) && lane0;
   wire wr_status = hit(i_avs_address, `FSX_REG_STATUS, take_wr) && lane0;
   // the base is wider than one lane, so it is always written whole
   wire wr_fsr2 = hit(i_avs_address, `FSX_REG_FSR2, take_wr);
   wire wr_cfg = hit(i_avs_address, `FSX_REG_CFG, take_wr) && lane0;
   wire do_sleep = finish && is_sleep;
   wire do_subb = finish && is_subb;

   // ----------------------------------------
   // sequencer: take, read operand, write back
   // ----------------------------------------
   always @(posedge i_clk)
   begin
      if (i_reset)
         state_r <= ST_IDLE;
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               if (wr_instr)
                  state_r <= ST_EXEC;
            end
            ST_EXEC:
               state_r <= ST_DONE;
            ST_DONE:
               state_r <= ST_IDLE;
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // instruction word
   // ----------------------------------------
   always @(posedge i_clk)
   begin
      if (i_reset)
         instr_r <= `FSX_INSTR_RST;
      else if (wr_instr)
         instr_r <= i_avs_writedata[15:0];
   end

   // ----------------------------------------
   // working, bank select, base and config registers
   // ----------------------------------------
   always @(posedge i_clk)
   begin
      if (i_reset)
         wreg_r <= `FSX_ZERO8;
      else if (wr_wreg)
         wreg_r <= i_avs_writedata[7:0];
      else if (do_subb && !dest_bit)
         wreg_r <= res;
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
         bank_select_reg_r <= `FSX_BANK_RST;
      else if (wr_bsr)
         bank_select_reg_r <= i_avs_writedata[3:0];
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
         fsr2_r <= {ADDR_W{1'b0}};
      else if (wr_fsr2)
         fsr2_r <= i_avs_writedata[ADDR_W-1:0];
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
         ext_set_r <= 1'b0;
      else if (wr_cfg)
         ext_set_r <= i_avs_writedata[0];
   end

   // ----------------------------------------
   // status flags
   // ----------------------------------------
   // a fill leaves every flag alone; a software write and an executing
   // instruction never meet, since writes are only taken while idle
   always @(posedge i_clk)
   begin
      if (i_reset)
         status_r <= `FSX_STATUS_RST;
      else if (wr_status)
         status_r <= i_avs_writedata[6:0];
      else if (do_sleep)
      begin
         status_r[`FSX_ST_TO] <= 1'b1;
         status_r[`FSX_ST_PD] <= 1'b0;
      end
      else if (do_subb)
      begin
         status_r[`FSX_ST_C] <= ~diff[8];
         status_r[`FSX_ST_DC] <= ~ldiff[4];
         status_r[`FSX_ST_Z] <= (res == `FSX_ZERO8);
         status_r[`FSX_ST_OV] <= ovf;
         status_r[`FSX_ST_N] <= res[7];
      end
   end

   // ----------------------------------------
   // watchdog counter and postscaler
   // ----------------------------------------
   // the clear outranks a tick in the same cycle, so the count restarts at zero
   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         postscaler_r <= `FSX_POST_ZERO;
         watchdog_counter_r <= `FSX_WDT_ZERO;
      end
      else if (do_sleep)
      begin
         postscaler_r <= `FSX_POST_ZERO;
         watchdog_counter_r <= `FSX_WDT_ZERO;
      end
      else if (i_wdt_tick)
      begin
         postscaler_r <= postscaler_r + 8'h01;
         if (postscaler_r == `FSX_ALL_ONES)
            watchdog_counter_r <= watchdog_counter_r + {{(WDT_W-1){1'b0}}, 1'b1};
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // holds the last answer until the next read is taken
   always @(posedge i_clk)
   begin
      if (i_reset)
         o_avs_readdata <= `FSX_WORD_ZERO;
      else if (take_rd)
      begin
         case (i_avs_address)
            `FSX_REG_INSTR: o_avs_readdata <= {16'h0000, instr_r};
            `FSX_REG_WREG: o_avs_readdata <= {24'h000000, wreg_r};
            `FSX_REG_BSR: o_avs_readdata <= {28'h0000000, bank_select_reg_r};
            `FSX_REG_STATUS: o_avs_readdata <= {25'h0000000, status_r};
            `FSX_REG_FSR2: o_avs_readdata <= {{(32-ADDR_W){1'b0}}, fsr2_r};
            `FSX_REG_WDT: o_avs_readdata <= {postscaler_r, {(24-WDT_W){1'b0}}, watchdog_counter_r};
            `FSX_REG_CFG: o_avs_readdata <= {31'h00000000, ext_set_r};
            default: o_avs_readdata <= `FSX_WORD_ZERO;
         endcase
      end
   end

   // ----------------------------------------
   // wait request
   // ----------------------------------------
   // low for one cycle per request; an instruction answers only once it
   // has run, so its effects are in place at the answer edge
   always @(posedge i_clk)
   begin
      if (i_reset)
         o_avs_waitrequest <= 1'b1;
      else if ((take_wr && !wr_instr) || take_rd || finish)
         o_avs_waitrequest <= 1'b0;
      else
         o_avs_waitrequest <= 1'b1;
   end

   // ----------------------------------------
   // low-power indication
   // ----------------------------------------
   // stays high from the end of a low-power entry until the next instruction
   always @(posedge i_clk)
   begin
      if (i_reset)
         o_sleeping <= 1'b0;
      else if (wr_instr)
         o_sleeping <= 1'b0;
      else if (do_sleep)
         o_sleeping <= 1'b1;
   end

endmodule // fsx_exec

/* testbench/fsx_exec_assertions.sv */
/* port checks for fsx_exec; assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module fsx_exec_assertions (
   input wire i_clk,
   input wire i_reset,
   input wire [2:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire o_avs_waitrequest,
   input wire o_sleeping
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // a pending sleep word, still waiting for its answer
   sequence sleep_req_s;
      i_avs_write && i_avs_address == 3'h0 && i_avs_writedata[15:0] == 16'h0003 && o_avs_waitrequest;
   endsequence
   sleep_flag_a: assert property (sleep_req_s |-> ##[1:4] !o_avs_waitrequest ##[0:1] o_sleeping)
      else $error("sleep not flagged");
   wait_pulse_a: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest) else $error("wait low twice");
   read_fast_a: assert property (i_avs_read && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("read late");
   instr_lat_a: assert property ($rose(i_avs_write) && i_avs_address == 3'h0 |->
      o_avs_waitrequest [*3] ##1 !o_avs_waitrequest) else $error("instruction timing");
   // an instruction word on a fresh strobe
   sequence instr_req_s;
      $rose(i_avs_write) && i_avs_address == 3'h0;
   endsequence
   // a register word, not an instruction, on a fresh strobe
   sequence reg_wr_s;
      $rose(i_avs_write) && i_avs_address != 3'h0;
   endsequence
   write_fast_a: assert property (reg_wr_s |=> !o_avs_waitrequest) else $error("register write late");
   sleep_clear_a: assert property (instr_req_s |=> !o_sleeping) else $error("sleep flag not cleared");
endmodule // fsx_exec_assertions
bind fsx_exec fsx_exec_assertions u_chk (.*);

/* testbench/fsx_exec_bench.sv */
/* fsx_exec bench; assumes answers follow waitrequest and reads back only memory cells it filled first. */
`timescale 1ns/100ps
module fsx_exec_bench;
   reg i_clk = 1'b0, i_reset = 1'b1, rd = 1'b0, wr = 1'b0, tk = 1'b0;
   reg [2:0] a = 3'h0;
   reg [31:0] wd = 32'h0, d;
   wire [31:0] q;
   wire wq, slp;
   integer bad_count = 0, num_checks = 0, cyc = 0;
   fsx_exec DUT (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(a), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .i_wdt_tick(tk), .o_avs_readdata(q),
      .o_avs_waitrequest(wq), .o_sleeping(slp));
   initial forever #50 i_clk = ~i_clk;
   always @(posedge i_clk)
   begin
      cyc = cyc + 1;
      bad_count = bad_count + (cyc == 3000);
      if (cyc == 3000)
         print_verdict;
   end
   task print_verdict;
   begin
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   task chk(input [31:0] e, input [31:0] g);
   begin
      num_checks = num_checks + 1;
      bad_count = bad_count + (g !== e);
      if (g !== e)
         $display("mismatch %0t %h %h", $time, e, g);
   end
   endtask
   // dropped after the answer, else a held strobe is taken twice
   task xf(input w, input [2:0] ad, input [31:0] v);
   begin
      @(posedge i_clk);
      {a, wd, rd, wr} <= {ad, v, !w, w};
      do @(posedge i_clk); while (wq !== 1'b0);
      d = q;
      {rd, wr} <= 2'b00;
   end
   endtask
   task rc(input [2:0] ad, input [31:0] e);
   begin
      xf(1'b0, ad, 32'h0);
      chk(e, d);
   end
   endtask
   task pk(input ab, input [7:0] f, input [7:0] e);
   begin
      xf(1'b1, 3'h1, 32'h0);
      xf(1'b1, 3'h3, 32'h1);
      xf(1'b1, 3'h0, {23'h2a, ab, f});
      rc(3'h1, {24'h0, ~e + 8'h01});
   end
   endtask
   initial
   begin
      repeat (4) @(posedge i_clk);
      i_reset <= 1'b0;
      rc(3'h3, 32'h60);
      xf(1'b1, 3'h2, 32'h2);
      xf(1'b1, 3'h3, 32'h1f);
      xf(1'b1, 3'h0, 32'h6940);
      rc(3'h3, 32'h1f);
      pk(1'b1, 8'h40, 8'hff);
      xf(1'b1, 3'h0, 32'h6840);
      xf(1'b1, 3'h1, 32'h2);
      xf(1'b1, 3'h3, 32'h1);
      xf(1'b1, 3'h0, 32'h5740);
      pk(1'b1, 8'h40, 8'h03);
      pk(1'b0, 8'h40, 8'hff);
      xf(1'b1, 3'h4, 32'h200);
      xf(1'b1, 3'h6, 32'h1);
      xf(1'b1, 3'h0, 32'h685f);
      xf(1'b1, 3'h0, 32'h6860);
      xf(1'b1, 3'h6, 32'h0);
      pk(1'b1, 8'h5f, 8'hff);
      pk(1'b0, 8'h60, 8'hff);
      xf(1'b1, 3'h1, 32'h5);
      xf(1'b1, 3'h3, 32'h0);
      xf(1'b1, 3'h0, 32'h5540);
      rc(3'h1, 32'h1);
      rc(3'h3, 32'h3);
      repeat (6) @(posedge i_clk) tk <= ~tk;
      rc(3'h5, 32'h03000000);
      xf(1'b1, 3'h3, 32'h3f);
      xf(1'b1, 3'h0, 32'h3);
      chk(32'h1, {31'h0, slp});
      rc(3'h3, 32'h5f);
      rc(3'h5, 32'h0);
      xf(1'b1, 3'h0, 32'h6940);
      chk(32'h0, {31'h0, slp});
      print_verdict;
   end
endmodule // fsx_exec_bench
